/* src/usf_pkg.sv */
package usf_pkg;
	// Register byte offsets (AXI4-Lite, one aligned word each)
	localparam logic [3:0] ADDR_STATUS  = 4'h0;
	localparam logic [3:0] ADDR_CONTROL = 4'h4;
	localparam logic [3:0] ADDR_TXDATA  = 4'h8;
	localparam logic [3:0] ADDR_RXDATA  = 4'hC;
	localparam int ADDR_W = 4;
	// Status bit positions
	localparam int BIT_TX_EMPTY  = 7;
	localparam int BIT_RX_FULL   = 6;
	localparam int BIT_OVERRUN   = 5;
	localparam int BIT_FRAMING   = 4;
	localparam int BIT_PARITY    = 3;
	localparam int BIT_TX_DONE   = 2;
	localparam int BIT_RSVD1     = 1;
	localparam int BIT_RSVD0     = 0;
	localparam logic [7:0] STATUS_RESET = 8'h84;
	// Control bit positions
	localparam int CTL_TX_EN   = 0;
	localparam int CTL_RX_EN   = 1;
	localparam int CTL_SYNC    = 2;
	localparam int CTL_PAR_EN  = 3;
	localparam int CTL_PAR_ODD = 4;
	localparam int CTL_TWO_STOP = 5;
	localparam int CTL_STANDBY = 6;
	localparam logic [6:0] CONTROL_RESET = 7'h00;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* src/usf_hold_reg.sv */
`timescale 1ns/100ps
module usf_hold_reg
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       we,
	input  wire logic [7:0] wdata,
	output logic      [7:0] rdata
);
	// Holding byte; read data comes straight from the register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rdata <= 8'h00;
		else if (we)
			rdata <= wdata;
	end
endmodule

/* src/usf_status.sv */
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module usf_status
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        rx_done,
	input  wire logic [7:0]  rx_shift_register,
	input  wire logic        rx_stop_bit,
	input  wire logic        rx_parity_bit,
	input  wire logic        tx_load,
	input  wire logic        tx_last_bit,
	output logic [7:0]       tx_holding_register,
	output logic             tx_go,
	output logic             rx_go,
	output logic [6:0]       serial_control
);
	logic [7:0] serial_status;
	logic [4:0] seen_one_q;
	logic       aw_q;
	logic       w_q;
	logic [3:0] awaddr_q;
	logic [7:0] wdata_q;
	logic       wlane_q;
	logic [7:0] rx_byte;
	logic       wr_fire;
	logic       rd_fire;
	logic       wr_stat;
	logic       wr_tx;
	logic       rd_stat;
	logic       rd_rx;
	logic       rx_accept;
	logic       fer_ev;
	logic       per_ev;
	logic       ovr_ev;
	logic       tx_en;
	logic       rx_en;
	logic       sync_m;
	logic       standby;
	logic       tde_clr;
	logic       err_any;
	logic       rx_store;

	assign tx_en   = serial_control[usf_pkg::CTL_TX_EN];
	assign rx_en   = serial_control[usf_pkg::CTL_RX_EN];
	assign sync_m  = serial_control[usf_pkg::CTL_SYNC];
	assign standby = serial_control[usf_pkg::CTL_STANDBY];

	// Write channel: address and data may come in either order
	assign wr_fire = aw_q && w_q && !s_axi_bvalid;
	assign wr_stat = wr_fire && awaddr_q == usf_pkg::ADDR_STATUS && wlane_q;
	assign wr_tx   = wr_fire && awaddr_q == usf_pkg::ADDR_TXDATA && wlane_q;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign rd_stat = rd_fire && s_axi_araddr == usf_pkg::ADDR_STATUS;
	assign rd_rx   = rd_fire && s_axi_araddr == usf_pkg::ADDR_RXDATA;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_q          <= 1'b0;
			w_q           <= 1'b0;
			awaddr_q      <= 4'h0;
			wdata_q       <= 8'h00;
			wlane_q       <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= usf_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_q     <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_q     <= 1'b1;
				wdata_q <= s_axi_wdata[7:0];
				wlane_q <= s_axi_wstrb[0];
			end
			if (wr_fire)
			begin
				aw_q         <= 1'b0;
				w_q          <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q == usf_pkg::ADDR_STATUS
					|| awaddr_q == usf_pkg::ADDR_CONTROL
					|| awaddr_q == usf_pkg::ADDR_TXDATA)
					? usf_pkg::RESP_OKAY : usf_pkg::RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Control register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			serial_control <= usf_pkg::CONTROL_RESET;
		else if (wr_fire && awaddr_q == usf_pkg::ADDR_CONTROL && wlane_q)
			serial_control <= wdata_q[6:0];
	end

	// Read channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= usf_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (rd_fire)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= usf_pkg::RESP_OKAY;
				case (s_axi_araddr)
					usf_pkg::ADDR_STATUS:  s_axi_rdata <= {24'h000000, serial_status};
					usf_pkg::ADDR_CONTROL: s_axi_rdata <= {25'h0, serial_control};
					usf_pkg::ADDR_TXDATA:  s_axi_rdata <= {24'h000000, tx_holding_register};
					usf_pkg::ADDR_RXDATA:  s_axi_rdata <= {24'h000000, rx_byte};
					default:
					begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= usf_pkg::RESP_SLVERR;
					end
				endcase
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Receive evaluation; stop bit only the first one, second never reaches here
	assign fer_ev    = !sync_m && !rx_stop_bit;
	assign per_ev    = !sync_m && serial_control[usf_pkg::CTL_PAR_EN]
		&& ((^rx_shift_register ^ rx_parity_bit) != serial_control[usf_pkg::CTL_PAR_ODD]);
	assign err_any   = serial_status[usf_pkg::BIT_OVERRUN] || serial_status[usf_pkg::BIT_FRAMING]
		|| serial_status[usf_pkg::BIT_PARITY];
	assign rx_accept = rx_done && rx_en && !err_any;
	assign ovr_ev    = rx_accept && serial_status[usf_pkg::BIT_RX_FULL];
	// Overrun discards; framing or parity still store the byte
	assign rx_store  = rx_accept && !ovr_ev;

	usf_hold_reg u_rx_hold
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.we      (rx_store),
		.wdata   (rx_shift_register),
		.rdata   (rx_byte)
	);

	// Receive halts on any error; sync mode also halts transmit on overrun or framing
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_go <= 1'b0;
			tx_go <= 1'b0;
		end
		else
		begin
			rx_go <= rx_en && !err_any;
			tx_go <= tx_en && !(sync_m && (serial_status[usf_pkg::BIT_OVERRUN]
				|| serial_status[usf_pkg::BIT_FRAMING]));
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			tx_holding_register <= 8'h00;
		else if (wr_tx)
			tx_holding_register <= wdata_q;
	end

	// Read-as-one record; a status write clears only seen flags, bit 2 clearing with a seen bit 7
	always_ff @(posedge aclk)
	begin
		if (!aresetn || standby)
			seen_one_q <= 5'h00;
		else if (rd_stat)
			seen_one_q <= serial_status[7:3] | seen_one_q;
		else if (wr_stat)
			seen_one_q <= 5'h00;
	end

	assign tde_clr = (wr_stat && !wdata_q[usf_pkg::BIT_TX_EMPTY]
		&& seen_one_q[4]) || wr_tx;

	// Status flags; set beats clear in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn || standby)
			serial_status <= usf_pkg::STATUS_RESET;
		else
		begin
			if (tde_clr)
			begin
				serial_status[usf_pkg::BIT_TX_EMPTY] <= 1'b0;
				serial_status[usf_pkg::BIT_TX_DONE]  <= 1'b0;
			end
			if (!tx_en || tx_load)
				serial_status[usf_pkg::BIT_TX_EMPTY] <= 1'b1;
			if (!tx_en || (tx_last_bit && serial_status[usf_pkg::BIT_TX_EMPTY]))
				serial_status[usf_pkg::BIT_TX_DONE] <= 1'b1;
			if ((wr_stat && !wdata_q[usf_pkg::BIT_RX_FULL] && seen_one_q[3]) || rd_rx)
				serial_status[usf_pkg::BIT_RX_FULL] <= 1'b0;
			if (rx_store && !fer_ev && !per_ev)
				serial_status[usf_pkg::BIT_RX_FULL] <= 1'b1;
			// Ones written are ignored; only a zero after a seen one clears
			if (wr_stat && !wdata_q[usf_pkg::BIT_OVERRUN] && seen_one_q[2])
				serial_status[usf_pkg::BIT_OVERRUN] <= 1'b0;
			if (wr_stat && !wdata_q[usf_pkg::BIT_FRAMING] && seen_one_q[1])
				serial_status[usf_pkg::BIT_FRAMING] <= 1'b0;
			if (wr_stat && !wdata_q[usf_pkg::BIT_PARITY] && seen_one_q[0])
				serial_status[usf_pkg::BIT_PARITY] <= 1'b0;
			if (ovr_ev)
				serial_status[usf_pkg::BIT_OVERRUN] <= 1'b1;
			if (rx_store && fer_ev)
				serial_status[usf_pkg::BIT_FRAMING] <= 1'b1;
			if (rx_store && per_ev)
				serial_status[usf_pkg::BIT_PARITY] <= 1'b1;
			serial_status[usf_pkg::BIT_RSVD1] <= 1'b0;
			if (wr_stat)
				serial_status[usf_pkg::BIT_RSVD0] <= wdata_q[usf_pkg::BIT_RSVD0];
		end
	end

	property p_full_on_clean;
		@(posedge aclk) disable iff (!aresetn)
		(rx_store && !fer_ev && !per_ev && !standby) |=> serial_status[usf_pkg::BIT_RX_FULL];
	endproperty
	a_full_on_clean: assert property (p_full_on_clean) else $error("rx full not set");

	property p_overrun_keep;
		@(posedge aclk) disable iff (!aresetn)
		(ovr_ev && !standby) |=> serial_status[usf_pkg::BIT_OVERRUN] && rx_byte == $past(rx_byte);
	endproperty
	a_overrun_keep: assert property (p_overrun_keep) else $error("overrun mishandled");

	property p_err_no_full;
		@(posedge aclk) disable iff (!aresetn)
		(rx_store && (fer_ev || per_ev) && !serial_status[usf_pkg::BIT_RX_FULL] && !rd_rx)
		|=> !serial_status[usf_pkg::BIT_RX_FULL];
	endproperty
	a_err_no_full: assert property (p_err_no_full) else $error("full set on error");

	property p_halt_rx;
		@(posedge aclk) disable iff (!aresetn)
		err_any |=> !rx_go;
	endproperty
	a_halt_rx: assert property (p_halt_rx) else $error("rx not halted");

	property p_sync_halt_tx;
		@(posedge aclk) disable iff (!aresetn)
		(sync_m && serial_status[usf_pkg::BIT_OVERRUN]) |=> !tx_go;
	endproperty
	a_sync_halt_tx: assert property (p_sync_halt_tx) else $error("tx not halted");

	property p_txdone_follow;
		@(posedge aclk) disable iff (!aresetn)
		(wr_tx && tx_en && !tx_load && !tx_last_bit && !standby)
		|=> !serial_status[usf_pkg::BIT_TX_DONE]
			&& !serial_status[usf_pkg::BIT_TX_EMPTY];
	endproperty
	a_txdone_follow: assert property (p_txdone_follow) else $error("tx flags not cleared");

	property p_tx_disable;
		@(posedge aclk) disable iff (!aresetn)
		!tx_en |=> serial_status[usf_pkg::BIT_TX_EMPTY] && serial_status[usf_pkg::BIT_TX_DONE];
	endproperty
	a_tx_disable: assert property (p_tx_disable) else $error("tx flags not set");

	property p_no_blind_clear;
		@(posedge aclk) disable iff (!aresetn)
		(wr_stat && !seen_one_q[2] && serial_status[usf_pkg::BIT_OVERRUN] && !standby)
		|=> serial_status[usf_pkg::BIT_OVERRUN];
	endproperty
	a_no_blind_clear: assert property (p_no_blind_clear) else $error("unseen clear");

	property p_bit1_zero;
		@(posedge aclk) disable iff (!aresetn)
		(wr_stat && !standby) |=> !serial_status[usf_pkg::BIT_RSVD1]
			&& serial_status[usf_pkg::BIT_RSVD0] == $past(wdata_q[usf_pkg::BIT_RSVD0]);
	endproperty
	a_bit1_zero: assert property (p_bit1_zero) else $error("bit1 written");
endmodule

/* verif/usf_serial_peer.sv */
`timescale 1ns/100ps
module usf_serial_peer
(
	input  wire logic       aclk,
	output logic            rx_done,
	output logic      [7:0] rx_shift_register,
	output logic            rx_stop_bit,
	output logic            rx_parity_bit,
	output logic            tx_load,
	output logic            tx_last_bit
);
	initial
	begin
		rx_done = 1'b0;
		rx_shift_register = 8'h00;
		rx_stop_bit = 1'b1;
		rx_parity_bit = 1'b0;
		tx_load = 1'b0;
		tx_last_bit = 1'b0;
	end
	// Lines flip after each character so a stale byte never looks valid
	task automatic rx_char(input logic [7:0] d, input logic stop, input logic par);
		@(posedge aclk);
		rx_done <= 1'b1;
		rx_shift_register <= d;
		rx_stop_bit <= stop;
		rx_parity_bit <= par;
		@(posedge aclk);
		rx_done <= 1'b0;
		rx_shift_register <= ~d;
		rx_stop_bit <= ~stop;
		rx_parity_bit <= ~par;
	endtask
	task automatic tx_pulse(input logic last);
		@(posedge aclk);
		tx_load <= ~last;
		tx_last_bit <= last;
		@(posedge aclk);
		tx_load <= 1'b0;
		tx_last_bit <= 1'b0;
	endtask
endmodule

/* verif/uart_status_flags_bench.sv */
`timescale 1ns/100ps
module uart_status_flags_bench;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata;
	logic        rx_done, rx_stop_bit, rx_parity_bit, tx_load, tx_last_bit, tx_go, rx_go;
	logic [7:0]  rx_shift_register, tx_holding_register, a, v;
	logic [6:0]  serial_control;
	logic [31:0] seed = 32'd44459;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          cyc = 0;

	always #2.5 aclk = ~aclk;

	usf_status DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_done,
		.rx_shift_register, .rx_stop_bit, .rx_parity_bit, .tx_load, .tx_last_bit,
		.tx_holding_register, .tx_go, .rx_go, .serial_control);
	usf_serial_peer peer (.aclk, .rx_done, .rx_shift_register, .rx_stop_bit,
		.rx_parity_bit, .tx_load, .tx_last_bit);

	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	function automatic logic pbit(input logic [7:0] d, input logic odd);
		return ^d ^ odd;
	endfunction
	task automatic end_sim();
		if (n_mismatch == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] ad, input logic [7:0] d, input logic [3:0] st = 4'hF);
		logic ad_ok;
		logic d_ok;
		ad_ok = 1'b0;
		d_ok = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad_ok && d_ok))
		begin
			@(posedge aclk);
			ad_ok = ad_ok | (s_axi_awready === 1'b1);
			d_ok = d_ok | (s_axi_wready === 1'b1);
			if (ad_ok)
				s_axi_awvalid <= 1'b0;
			if (d_ok)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1)
			@(posedge aclk);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] ad, output logic [7:0] d);
		@(posedge aclk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1)
			@(posedge aclk);
		d = s_axi_rdata[7:0];
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Every status read arms the clear records, so clears write 1 to kept bits
	task automatic rs(input logic [7:0] exp);
		rd(usf_pkg::ADDR_STATUS, v);
		chk("status", v, exp);
	endtask
	task automatic rr(input logic [7:0] exp);
		rd(usf_pkg::ADDR_RXDATA, v);
		chk("rx_data", v, exp);
	endtask
	task automatic ws(input logic [7:0] d);
		wr(usf_pkg::ADDR_STATUS, d);
	endtask
	task automatic wc(input logic [7:0] d);
		wr(usf_pkg::ADDR_CONTROL, d);
	endtask
	task automatic go(input logic [7:0] exp);
		chk("go", {6'h0, tx_go, rx_go}, exp);
	endtask

	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_mismatch++;
			end_sim();
		end
	end

	initial
	begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rs(8'h84);
		chk("rresp", {6'h0, resp}, {6'h0, usf_pkg::RESP_OKAY});
		go(8'h00);
		// Unmapped offsets answer with an error and touch nothing
		wr(4'h2, 8'h00);
		chk("bresp", {6'h0, resp}, {6'h0, usf_pkg::RESP_SLVERR});
		rd(4'h6, v);
		chk("rresp", {6'h0, resp}, {6'h0, usf_pkg::RESP_SLVERR});
		chk("rd_unmapped", v, 8'h00);
		rs(8'h84);
		wc(8'h03);
		chk("bresp", {6'h0, resp}, {6'h0, usf_pkg::RESP_OKAY});
		chk("control", {1'b0, serial_control}, 8'h03);
		rd(usf_pkg::ADDR_CONTROL, v);
		chk("control_rd", v, 8'h03);
		a = rnd();
		wr(usf_pkg::ADDR_TXDATA, a);
		rs(8'h00);
		chk("tx_hold", tx_holding_register, a);
		rd(usf_pkg::ADDR_TXDATA, v);
		chk("tx_hold_rd", v, a);
		peer.tx_pulse(1'b0);
		rs(8'h80);
		peer.tx_pulse(1'b1);
		rs(8'h84);
		ws(8'h7C);
		rs(8'h00);
		peer.tx_pulse(1'b0);
		ws(8'h7C);
		rs(8'h80);
		wr(usf_pkg::ADDR_TXDATA, rnd());
		wc(8'h02);
		rs(8'h84);
		wc(8'h03);
		ws(8'hFA);
		rs(8'h84);
		wr(usf_pkg::ADDR_STATUS, 8'h00, 4'h0);
		rs(8'h84);
		go(8'h03);
		repeat (4)
		begin
			a = rnd();
			peer.rx_char(a, 1'b1, 1'b0);
			rs(8'hC4);
			rr(a);
			rs(8'h84);
		end
		peer.rx_char(rnd(), 1'b1, 1'b0);
		rs(8'hC4);
		ws(8'hBE);
		rs(8'h84);
		a = rnd();
		peer.rx_char(a, 1'b1, 1'b0);
		peer.rx_char(~a, 1'b1, 1'b0);
		rs(8'hE4);
		go(8'h02);
		wc(8'h01);
		peer.rx_char(rnd(), 1'b1, 1'b0);
		rs(8'hE4);
		wc(8'h03);
		ws(8'hDE);
		rs(8'hC4);
		rr(a);
		a = rnd();
		peer.rx_char(a, 1'b0, 1'b0);
		rs(8'h94);
		go(8'h02);
		peer.rx_char(~a, 1'b1, 1'b0);
		rr(a);
		ws(8'hEE);
		rs(8'h84);
		for (int k = 0; k < 2; k++)
		begin
			a = rnd();
			wc({3'h0, k[0], 4'hB});
			peer.rx_char(a, 1'b1, pbit(a, k[0]));
			rs(8'hC4);
			rr(a);
			peer.rx_char(a, 1'b1, ~pbit(a, k[0]));
			rs(8'h8C);
			go(8'h02);
			rr(a);
			ws(8'hF6);
			rs(8'h84);
		end
		wc(8'h07);
		peer.rx_char(rnd(), 1'b1, 1'b0);
		peer.rx_char(rnd(), 1'b1, 1'b0);
		// No overrun record armed yet, so this zero must not clear the overrun
		ws(8'hDE);
		rs(8'hE4);
		go(8'h00);
		ws(8'hDE);
		rd(usf_pkg::ADDR_RXDATA, v);
		rs(8'h84);
		go(8'h03);
		wr(usf_pkg::ADDR_TXDATA, rnd());
		wc(8'h43);
		rs(8'h84);
		end_sim();
	end
endmodule
